// >>> sai_indicators.sv
/*
 * Alarm pad, buzzer square wave and status lamp blink generator.
 * Assumes call firmware drives ctrl and status on core_clk; the slow clock
 * is an unrelated external square wave and is synchronised here.
 */
// What this block does
// - Alarm pad rises when the alarm time arrives in alarm mode.
// - Alarm pad stays high until the clear command or until alarm mode is left, then goes low.
// - During reset the alarm pad is forced high.
// - Buzzer pad plays square-wave tones in buzzer mode.
// - Indicator shows service and call state: off dark, call steadily lit.
// - Indicator pin level is the inverse of the lamp state.
// - Searching: 1s period, 0,5s lit.
// - Registered, no call: 3s period, 0,3s lit.
module sai_indicators #(
	// Blink counts in slow clock ticks
	parameter int FAST_PERIOD = sai_pkg::FAST_PERIOD_TICKS,
	parameter int FAST_ON = sai_pkg::FAST_ON_TICKS,
	parameter int SLOW_PERIOD = sai_pkg::SLOW_PERIOD_TICKS,
	parameter int SLOW_ON = sai_pkg::SLOW_ON_TICKS
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic slow_clock_input,
	input wire sai_pkg::sai_ctrl_t ctrl,
	input wire sai_pkg::sai_status_t status,
	output logic alarm_pad,
	output logic buzzer_pad,
	output logic status_indicator_pin
);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	// Counts that overflow the blink counter would wrap and blink at a
	// wrong rate, so they are refused here rather than found on a bench
	localparam int TICK_MAX = (1 << sai_pkg::TICK_W) - 1;

	if (FAST_PERIOD < 2 || FAST_PERIOD > TICK_MAX) begin : g_bad_fast_period
		$error("Fast blink period does not fit the counter");
	end
	if (FAST_ON < 1 || FAST_ON >= FAST_PERIOD) begin : g_bad_fast_on
		$error("Fast blink lit time must be inside its period");
	end
	if (SLOW_PERIOD < 2 || SLOW_PERIOD > TICK_MAX) begin : g_bad_slow_period
		$error("Slow blink period does not fit the counter");
	end
	if (SLOW_ON < 1 || SLOW_ON >= SLOW_PERIOD) begin : g_bad_slow_on
		$error("Slow blink lit time must be inside its period");
	end

	// ************************************************************
	// Slow clock synchroniser and edge tick
	// ************************************************************
	logic slow_meta;
	logic slow_sync;
	logic slow_prev;
	logic slow_tick;

	// The slow wave is unrelated to core_clk: two flops before any logic
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			slow_meta <= 1'b0;
			slow_sync <= 1'b0;
			slow_prev <= 1'b0;
		end else begin
			slow_meta <= slow_clock_input;
			slow_sync <= slow_meta;
			slow_prev <= slow_sync;
		end
	end

	// A grounded slow clock gives no ticks, so the blink simply freezes
	assign slow_tick = slow_sync & ~slow_prev;

	// ************************************************************
	// Alarm pad
	// ************************************************************
	logic alarm_latched;
	logic next_alarm_latched;

	always_comb begin
		next_alarm_latched = alarm_latched;
		if (ctrl.alarm_fire) begin
			// Alarm arrival wins over a simultaneous clear
			next_alarm_latched = 1'b1;
		end else if (ctrl.alarm_clear) begin
			next_alarm_latched = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			alarm_latched <= 1'b0;
		end else begin
			alarm_latched <= next_alarm_latched;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			alarm_pad <= 1'b1;
		end else begin
			alarm_pad <= ctrl.alarm_mode & alarm_latched;
		end
	end

	// ************************************************************
	// Buzzer tone generator
	// ************************************************************
	logic [sai_pkg::TONE_W-1:0] tone_count;
	logic [sai_pkg::TONE_W-1:0] next_tone_count;
	logic next_buzzer_pad;
	logic tone_on;

	// A zero half period would wrap the compare limit to all ones and toggle
	// only every 65536 cycles, a tone nobody asked for, so it is treated as silence
	assign tone_on = ctrl.buzzer_mode & ctrl.buzzer_enable &
		(ctrl.tone_half_period != '0);

	always_comb begin
		next_tone_count = tone_count + 1'b1;
		next_buzzer_pad = buzzer_pad;
		if (!tone_on) begin
			next_tone_count = '0;
			next_buzzer_pad = 1'b0;
		end else if (tone_count >= ctrl.tone_half_period - 1'b1) begin
			next_tone_count = '0;
			next_buzzer_pad = ~buzzer_pad;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tone_count <= '0;
			buzzer_pad <= 1'b0;
		end else begin
			tone_count <= next_tone_count;
			buzzer_pad <= next_buzzer_pad;
		end
	end

	// ************************************************************
	// Status lamp blink
	// ************************************************************
	sai_pkg::sai_status_t status_prev;
	logic [sai_pkg::TICK_W-1:0] blink_count;
	logic [sai_pkg::TICK_W-1:0] next_blink_count;
	logic [sai_pkg::TICK_W-1:0] period_ticks;
	logic [sai_pkg::TICK_W-1:0] on_ticks;
	logic lamp_on;

	always_comb begin
		case (status)
			sai_pkg::SAI_SEARCHING: begin
				period_ticks = sai_pkg::TICK_W'(FAST_PERIOD);
				on_ticks = sai_pkg::TICK_W'(FAST_ON);
			end
			sai_pkg::SAI_REGISTERED: begin
				period_ticks = sai_pkg::TICK_W'(SLOW_PERIOD);
				on_ticks = sai_pkg::TICK_W'(SLOW_ON);
			end
			default: begin
				period_ticks = '0;
				on_ticks = '0;
			end
		endcase
	end

	// A changed status wins over a tick, so a new pattern always begins
	// with a full lit phase
	always_comb begin
		next_blink_count = blink_count;
		if (status != status_prev) begin
			next_blink_count = '0;
		end else if (slow_tick) begin
			if (blink_count >= period_ticks - 1'b1) begin
				next_blink_count = '0;
			end else begin
				next_blink_count = blink_count + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_prev <= sai_pkg::SAI_DEV_OFF;
			blink_count <= '0;
		end else begin
			status_prev <= status;
			blink_count <= next_blink_count;
		end
	end

	// The counter clears one edge after a change; until then the stale
	// count must not show a dark phase, so a fresh searching or registered status is lit at once
	always_comb begin
		case (status)
			sai_pkg::SAI_DEV_OFF: lamp_on = 1'b0;
			sai_pkg::SAI_CALL_ACTIVE: lamp_on = 1'b1;
			default: begin
				if (status != status_prev) begin
					lamp_on = 1'b1;
				end else begin
					lamp_on = (blink_count < on_ticks);
				end
			end
		endcase
	end

	// Pin idles high in reset so the lamp stays dark

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_indicator_pin <= 1'b1;
		end else begin
			status_indicator_pin <= ~lamp_on;
		end
	end

endmodule : sai_indicators

// >>> sai_indicators_chk.sv
/* Checker on sai_indicators ports.
 Assumes bind by port name. */
module sai_indicators_chk (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire sai_pkg::sai_ctrl_t ctrl,
	input wire sai_pkg::sai_status_t status,
	input wire logic alarm_pad,
	input wire logic buzzer_pad,
	input wire logic status_indicator_pin
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	property p_set; ctrl.alarm_fire ##1 ctrl.alarm_mode |=> alarm_pad; endproperty
	a_set: assert property (p_set) else $error("no alarm");
	property p_clr; ctrl.alarm_clear && !ctrl.alarm_fire |-> ##2 !alarm_pad;
	endproperty
	a_clr: assert property (p_clr) else $error("no clear");
	property p_mode; !ctrl.alarm_mode |=> !alarm_pad; endproperty
	a_mode: assert property (p_mode) else $error("pad mode");
	property p_rst; disable iff (1'b0) !rst_n |-> alarm_pad; endproperty
	a_rst: assert property (p_rst) else $error("reset pad");
	property p_off; (status == 2'h0) [*3] |-> status_indicator_pin; endproperty
	a_off: assert property (p_off) else $error("lamp lit");
	property p_call; (status == 2'h3) [*3] |-> !status_indicator_pin; endproperty
	a_call: assert property (p_call) else $error("lamp dark");
	property p_buz; !(ctrl.buzzer_mode && ctrl.buzzer_enable) |=> !buzzer_pad;
	endproperty
	a_buz: assert property (p_buz) else $error("tone");
	property p_lit; $changed(status) && (status[1] ^ status[0]) ##1
		$stable(status) [*2] |-> !status_indicator_pin; endproperty
	a_lit: assert property (p_lit) else $error("no restart");
endmodule : sai_indicators_chk
bind sai_indicators sai_indicators_chk sai_indicators_chk_inst (.*);

// >>> sai_indicators_test.sv
/* Bench for sai_indicators.
 Assumes one slow tick per three core cycles. */
module sai_indicators_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rst_n = 1'b1;
	logic slow;
	logic alarm_pad, buzzer_pad, status_indicator_pin;
	sai_pkg::sai_ctrl_t ctrl = '0;
	sai_pkg::sai_status_t status = sai_pkg::SAI_DEV_OFF;
	int error_cnt = 0;
	int n_compared = 0;
	int n;
	always #2 core_clk = ~core_clk;
	sai_slow_src sai_slow_src_inst (.clk32(slow));
	sai_indicators sai_indicators_inst (.core_clk(core_clk), .rst_n(rst_n),
		.slow_clock_input(slow), .ctrl(ctrl), .status(status),
		.alarm_pad(alarm_pad), .buzzer_pad(buzzer_pad),
		.status_indicator_pin(status_indicator_pin));
	task automatic ck(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t level", $time);
		end
	endtask : ck
	task automatic ck_n(input int got, input int lo, input int hi);
		n_compared++;
		if (got < lo || got > hi) begin
			error_cnt++;
			$display("BAD %0t span %0d", $time, got);
		end
	endtask : ck_n
	task automatic complete_run;
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run
	task automatic ed(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask : ed
	// Cycles s holds lvl once reached; 0 if never reached
	task automatic span(ref logic s, input logic lvl);
		n = 0;
		for (int i = 0; i < 40 && s !== lvl; i++)
			ed(1);
		while (s === lvl && n < 60000) begin
			ed(1);
			n++;
		end
	endtask : span
	task automatic t_alarm;
		@(posedge core_clk);
		ctrl.alarm_mode <= 1'b1;
		ctrl.alarm_fire <= 1'b1;
		@(posedge core_clk);
		ctrl.alarm_fire <= 1'b0;
		ed(8);
		ck(alarm_pad, 1'b1);
		@(posedge core_clk);
		ctrl.alarm_clear <= 1'b1;
		@(posedge core_clk);
		ctrl.alarm_clear <= 1'b0;
		ed(2);
		ck(alarm_pad, 1'b0);
	endtask : t_alarm
	task automatic t_buzz;
		@(posedge core_clk);
		ctrl.buzzer_mode <= 1'b1;
		ctrl.buzzer_enable <= 1'b1;
		ctrl.tone_half_period <= 16'h0005;
		span(buzzer_pad, 1'b1);
		ck_n(n, 5, 5);
		@(posedge core_clk);
		ctrl.buzzer_enable <= 1'b0;
		ed(3);
		ck(buzzer_pad, 1'b0);
	endtask : t_buzz
	task automatic t_blink(input sai_pkg::sai_status_t s, input int tk);
		@(posedge core_clk);
		status <= s;
		span(status_indicator_pin, 1'b0);
		ck_n(n, tk * 3 - 4, tk * 3 + 4);
	endtask : t_blink
	task automatic t_call;
		@(posedge core_clk);
		status <= sai_pkg::SAI_CALL_ACTIVE;
		ed(6);
		ck(status_indicator_pin, 1'b0);
		@(posedge core_clk);
		status <= sai_pkg::SAI_DEV_OFF;
		ed(6);
		ck(status_indicator_pin, 1'b1);
	endtask : t_call
	initial begin
		rst_n <= 1'b0;
		ed(2);
		ck(alarm_pad, 1'b1);
		@(posedge core_clk);
		rst_n <= 1'b1;
		t_alarm();
		t_buzz();
		t_blink(sai_pkg::SAI_SEARCHING, 16384);
		t_blink(sai_pkg::SAI_REGISTERED, 9830);
		t_call();
		complete_run();
	end
	initial begin
		#450000;
		error_cnt++;
		complete_run();
	end
endmodule : sai_indicators_test

// >>> sai_pkg.sv
/*
 * Package for the status, alarm and buzzer indicator outputs.
 * Assumes a 250 MHz core clock and a 32.768 kHz slow clock sampled as data.
 */
package sai_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int SLOW_CLOCK_HZ = 32768;
	localparam int FAST_PERIOD_MS = 1000;
	localparam int FAST_ON_MS = 500;
	localparam int SLOW_PERIOD_MS = 3000;
	localparam int SLOW_ON_MS = 300;
	localparam int FAST_PERIOD_TICKS = SLOW_CLOCK_HZ * FAST_PERIOD_MS / 1000;
	localparam int FAST_ON_TICKS = SLOW_CLOCK_HZ * FAST_ON_MS / 1000;
	localparam int SLOW_PERIOD_TICKS = SLOW_CLOCK_HZ * SLOW_PERIOD_MS / 1000;
	localparam int SLOW_ON_TICKS = SLOW_CLOCK_HZ * SLOW_ON_MS / 1000;
	localparam int TICK_W = 17;
	localparam int TONE_W = 16;

	// ************************************************************
	// Status codes
	// ************************************************************
	typedef enum logic [1:0] {
		SAI_DEV_OFF,
		SAI_SEARCHING,
		SAI_REGISTERED,
		SAI_CALL_ACTIVE
	} sai_status_t;

	// ************************************************************
	// Firmware-side controls
	// ************************************************************
	typedef struct packed {
		logic alarm_mode;
		logic alarm_fire;
		logic alarm_clear;
		logic buzzer_mode;
		logic buzzer_enable;
		logic [TONE_W-1:0] tone_half_period;
	} sai_ctrl_t;

endpackage : sai_pkg

// >>> sai_slow_src.sv
/* Sped-up slow square wave, 12 ns period.
 Assumes a 4 ns core clock; offset keeps edges apart. */
module sai_slow_src (
	output logic clk32
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		clk32 = 1'b0;
		#0.7;
		forever #6 clk32 = ~clk32;
	end
endmodule : sai_slow_src
